// *** logic/voice_gain_tone_generator.sv ***
// Voice gain, autonull, DTMF and ringer datapath of the telephone DSP
`timescale 1ns/1ns
module voice_gain_tone_generator
   import voice_dsp_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Register port
   input wire logic regWrEn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData,
   // Frame pulse pin
   input wire logic framePulse,
   // Linear PCM in
   input wire logic signed [15:0] rxPcm,
   input wire logic signed [15:0] txPcm,
   // Linear PCM out
   output logic signed [15:0] rxOut,
   output logic signed [15:0] txOut,
   output logic sampleValid,
   // New call tone toggle
   output logic newCallTone
);
   import voice_dsp_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Functions
   function automatic logic signed [15:0] applyGain(
      input logic signed [15:0] x, input logic [5:0] code);
      logic [15:0] mant;
      logic signed [32:0] prod;
      logic signed [32:0] sh;
      logic [4:0] amt;
      mant = GAIN_MANT0;
      case (code[1:0])
         2'h1: mant = GAIN_MANT1;
         2'h2: mant = GAIN_MANT2;
         2'h3: mant = GAIN_MANT3;
         default: mant = GAIN_MANT0;
      endcase
      prod = x * $signed({1'b0, mant});
      amt = GAIN_SHIFT_BASE - {1'b0, code[5:2]};
      sh = prod >>> amt;
      if (sh > 33'sh0_7fff) begin
         applyGain = 16'sh7fff;
      end else if (sh < -33'sh0_8000) begin
         applyGain = -16'sh8000;
      end else begin
         applyGain = sh[15:0];
      end
   endfunction : applyGain

   function automatic logic signed [15:0] toneWave(
      input logic [9:0] ph, input logic [12:0] amp);
      logic [16:0] a;
      logic [16:0] pp;
      logic [29:0] m;
      a = {8'h00, ph[8:0]};
      pp = 17'(a * (17'h0_0200 - a));
      m = {13'h0000, pp} * {17'h0_0000, amp};
      if (ph[9]) begin
         toneWave = -$signed({3'h0, m[28:16]});
      end else begin
         toneWave = $signed({3'h0, m[28:16]});
      end
   endfunction : toneWave

   ////////////////////////////////////////////////////////////////////////
   // Frame pulse synchroniser
   logic [2:0] fSync_q;
   logic frameTick;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         fSync_q <= 3'h0;
      end else begin
         fSync_q <= {fSync_q[1:0], framePulse};
      end
   end
   assign frameTick = fSync_q[1] & ~fSync_q[2];

   ////////////////////////////////////////////////////////////////////////
   // Registers
   logic [5:0] rxGain_q;
   logic autoNull_q;
   logic [2:0] pgmSel_q;
   logic altRing_q;
   logic toneToTx_q;
   logic holdReset_q;
   logic [7:0] txSpeech_q;
   logic [7:0] txTone_q;
   logic [7:0] coefLo_q;
   logic [7:0] coefHi_q;
   logic [7:0] warble_q;
   dsp_state_e state_q;
   logic running;
   logic memWrOk;
   assign running = (state_q == ST_RUN);
   assign memWrOk = regWrEn & holdReset_q;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         rxGain_q <= RESET_VALUE[5:0];
         autoNull_q <= 1'b0;
         pgmSel_q <= RESET_VALUE[2:0];
         altRing_q <= 1'b0;
         toneToTx_q <= 1'b0;
         holdReset_q <= 1'b0;
      end else begin
         if (running && frameTick && pgmSel_q == PGM_INIT) begin
            rxGain_q <= INIT_RX_GAIN;
         end
         if (regWrEn && regAddr == OFF_RX_GAIN) begin
            rxGain_q <= regWrData[5:0];
            autoNull_q <= regWrData[RXG_AUTONULL_BIT];
         end
         if (regWrEn && regAddr == OFF_DSP_CTRL) begin
            pgmSel_q <= regWrData[CTL_PGM_LSB +: 3];
            altRing_q <= regWrData[CTL_ALT_RING_BIT];
            toneToTx_q <= regWrData[CTL_TONE_TX_BIT];
            holdReset_q <= regWrData[CTL_HOLD_BIT];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         txSpeech_q <= RESET_VALUE;
         txTone_q <= RESET_VALUE;
         coefLo_q <= RESET_VALUE;
         coefHi_q <= RESET_VALUE;
         warble_q <= RESET_VALUE;
      end else begin
         if (running && frameTick && pgmSel_q == PGM_INIT) begin
            txSpeech_q <= INIT_TX_SPEECH;
            txTone_q <= INIT_TX_TONE;
         end
         if (memWrOk) begin
            case (regAddr)
               OFF_TX_SPEECH: txSpeech_q <= regWrData;
               OFF_TX_TONE: txTone_q <= regWrData;
               OFF_COEF_LOW: coefLo_q <= regWrData;
               OFF_COEF_HIGH: coefHi_q <= regWrData;
               OFF_WARBLE: warble_q <= regWrData;
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         regRdData <= 8'h00;
      end else begin
         case (regAddr)
            OFF_RX_GAIN: regRdData <= {1'b0, autoNull_q, rxGain_q};
            OFF_DSP_CTRL: regRdData <= {holdReset_q, running, 1'b0,
               toneToTx_q, altRing_q, pgmSel_q};
            OFF_TX_SPEECH: regRdData <= txSpeech_q;
            OFF_TX_TONE: regRdData <= txTone_q;
            OFF_COEF_LOW: regRdData <= coefLo_q;
            OFF_COEF_HIGH: regRdData <= coefHi_q;
            OFF_WARBLE: regRdData <= warble_q;
            default: regRdData <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer
   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_q <= ST_HELD;
      end else if (regWrEn && regAddr == OFF_DSP_CTRL) begin
         state_q <= regWrData[CTL_HOLD_BIT] ? ST_HELD : ST_WAIT;
      end else if (holdReset_q) begin
         state_q <= ST_HELD;
      end else begin
         case (state_q)
            ST_HELD: state_q <= ST_HELD;
            ST_WAIT: if (frameTick) begin
               state_q <= ST_RUN;
            end
            ST_RUN: state_q <= ST_RUN;
            default: state_q <= ST_HELD;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Tone and ringer generators
   logic [9:0] phaseLo_q;
   logic [9:0] phaseHi_q;
   logic [7:0] ringCnt_q;
   logic [11:0] warbleCnt_q;
   logic ringSel_q;
   logic [7:0] ringCoef;
   logic [11:0] warbleLim;
   logic ringHigh;
   logic dtmfOn;
   logic ringOn;
   assign dtmfOn = running && pgmSel_q == PGM_DTMF;
   assign ringOn = running && pgmSel_q == PGM_RING;
   assign ringCoef = ringSel_q ? coefHi_q : coefLo_q;
   assign warbleLim = 12'({4'h0, warble_q} << WARBLE_SHIFT) - 12'h001;
   assign ringHigh = ringCnt_q < {1'b0, ringCoef[7:1]};

   always_ff @(posedge clk) begin
      if (!rstn) begin
         phaseLo_q <= 10'h000;
         phaseHi_q <= 10'h000;
      end else if (frameTick && dtmfOn) begin
         phaseLo_q <= phaseLo_q + {2'h0, coefLo_q};
         phaseHi_q <= phaseHi_q + {2'h0, coefHi_q};
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         ringCnt_q <= 8'h00;
         warbleCnt_q <= 12'h000;
         ringSel_q <= 1'b0;
      end else if (frameTick && ringOn) begin
         if (ringCnt_q + 8'h01 >= ringCoef) begin
            ringCnt_q <= 8'h00;
         end else begin
            ringCnt_q <= ringCnt_q + 8'h01;
         end
         if (warble_q != 8'h00 && warbleCnt_q >= warbleLim) begin
            warbleCnt_q <= 12'h000;
            ringSel_q <= ~ringSel_q;
         end else begin
            warbleCnt_q <= warbleCnt_q + 12'h001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmit autonull
   logic signed [23:0] dcEst_q;
   logic signed [24:0] dcDiff;
   logic signed [15:0] dcRound;
   logic signed [15:0] txNulled;
   assign dcDiff = $signed({txPcm[15], txPcm, 8'h00}) -
      $signed({dcEst_q[23], dcEst_q});
   assign dcRound = dcEst_q[23:8] + {15'h0000, dcEst_q[7]};
   assign txNulled = autoNull_q ? 16'(txPcm - dcRound) : txPcm;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         dcEst_q <= 24'h00_0000;
      end else if (frameTick && running && autoNull_q) begin
         dcEst_q <= dcEst_q + 24'(dcDiff >>> NULL_SHIFT);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output datapath
   logic signed [15:0] toneSum;
   logic signed [15:0] ringPcm;
   logic signed [15:0] rxGained;
   logic signed [15:0] txGained;
   logic signed [15:0] toneLo;
   assign toneLo = (coefLo_q == 8'h00) ? 16'sh0000 :
      toneWave(phaseLo_q + QUARTER_PHASE, LOW_TONE_AMP);
   assign toneSum = toneLo +
      toneWave(phaseHi_q + QUARTER_PHASE, HIGH_TONE_AMP);
   assign ringPcm = ringHigh ? $signed(RING_AMP) : -$signed(RING_AMP);
   assign rxGained = applyGain(rxPcm, rxGain_q);
   assign txGained = applyGain(txNulled, txSpeech_q[5:0]);

   always_ff @(posedge clk) begin
      if (!rstn) begin
         rxOut <= 16'sh0000;
         txOut <= 16'sh0000;
      end else if (frameTick) begin
         rxOut <= rxPcm;
         txOut <= txPcm;
         if (running) begin
            case (pgmSel_q)
               PGM_GAIN: begin
                  rxOut <= rxGained;
                  txOut <= txGained;
               end
               PGM_DTMF: begin
                  rxOut <= toneToTx_q ? rxGained :
                     applyGain(toneSum, rxGain_q);
                  txOut <= toneToTx_q ?
                     applyGain(toneSum, txTone_q[5:0]) : txGained;
               end
               PGM_RING: begin
                  rxOut <= altRing_q ? rxGained :
                     applyGain(ringPcm, rxGain_q);
                  txOut <= txGained;
               end
               default: begin
                  rxOut <= rxPcm;
                  txOut <= txPcm;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         sampleValid <= 1'b0;
         newCallTone <= 1'b0;
      end else begin
         sampleValid <= frameTick;
         if (!(ringOn && altRing_q)) begin
            newCallTone <= 1'b0;
         end else if (frameTick) begin
            newCallTone <= ringHigh;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   AST_START_ON_FRAME: assert property (@(posedge clk) disable iff (!rstn)
      state_q == ST_WAIT && !frameTick
      |=> state_q != ST_RUN)
      else $error("program started off a frame boundary");
   AST_INIT_DEFAULTS: assert property (@(posedge clk) disable iff (!rstn)
      running && frameTick && pgmSel_q == PGM_INIT && !regWrEn
      |=> rxGain_q == INIT_RX_GAIN && txSpeech_q == INIT_TX_SPEECH
      && txTone_q == INIT_TX_TONE)
      else $error("init program did not load defaults");
   AST_RX_UNITY: assert property (@(posedge clk) disable iff (!rstn)
      running && frameTick && pgmSel_q == PGM_GAIN
      && rxGain_q == GAIN_UNITY |=> rxOut == $past(rxPcm))
      else $error("unity receive gain altered sample");
   AST_TX_UNITY: assert property (@(posedge clk) disable iff (!rstn)
      running && frameTick && !autoNull_q
      && (pgmSel_q == PGM_GAIN || pgmSel_q == PGM_RING)
      && txSpeech_q[5:0] == GAIN_UNITY |=> txOut == $past(txPcm))
      else $error("unity transmit gain altered sample");
   AST_HI_PHASE: assert property (@(posedge clk) disable iff (!rstn)
      frameTick && dtmfOn
      |=> phaseHi_q == $past(phaseHi_q) + {2'h0, $past(coefHi_q)})
      else $error("high group phase step wrong");
   AST_SINGLE_TONE: assert property (@(posedge clk) disable iff (!rstn)
      dtmfOn && coefLo_q == 8'h00
      |-> toneSum <= $signed({3'h0, HIGH_TONE_AMP})
      && toneSum >= -$signed({3'h0, HIGH_TONE_AMP}))
      else $error("low group present with zero coefficient");
   AST_WARBLE: assert property (@(posedge clk) disable iff (!rstn)
      $changed(ringSel_q) |-> $past(warbleCnt_q) >= $past(warbleLim)
      && $past(frameTick))
      else $error("ringer switched before warble period");
   AST_RING_LEVEL: assert property (@(posedge clk) disable iff (!rstn)
      ringOn && frameTick && !altRing_q && rxGain_q == GAIN_UNITY
      |=> rxOut == $signed(RING_AMP) || rxOut == -$signed(RING_AMP))
      else $error("ringer level not mid amplitude");
   AST_ALT_SPEECH: assert property (@(posedge clk) disable iff (!rstn)
      ringOn && frameTick && altRing_q && rxGain_q == GAIN_UNITY
      |=> rxOut == $past(rxPcm))
      else $error("alternate ring disturbed speech");
   AST_HELD_WRITE: assert property (@(posedge clk) disable iff (!rstn)
      regWrEn && !holdReset_q && regAddr == OFF_COEF_HIGH
      |=> $stable(coefHi_q))
      else $error("memory register written while running");
endmodule : voice_gain_tone_generator

// *** logic/voice_dsp_pkg.sv ***
// Constants shared by the voice gain and tone generator
package voice_dsp_pkg;
   // Register offsets
   localparam logic [7:0] OFF_RX_GAIN = 8'h1d;
   localparam logic [7:0] OFF_DSP_CTRL = 8'h1e;
   localparam logic [7:0] OFF_TX_SPEECH = 8'h20;
   localparam logic [7:0] OFF_TX_TONE = 8'h21;
   localparam logic [7:0] OFF_COEF_LOW = 8'h23;
   localparam logic [7:0] OFF_COEF_HIGH = 8'h24;
   localparam logic [7:0] OFF_WARBLE = 8'h26;
   // Field positions
   localparam int RXG_AUTONULL_BIT = 6;
   localparam int CTL_PGM_LSB = 0;
   localparam int CTL_ALT_RING_BIT = 3;
   localparam int CTL_TONE_TX_BIT = 4;
   localparam int CTL_RUNNING_BIT = 6;
   localparam int CTL_HOLD_BIT = 7;
   // Program select codes
   typedef enum logic [2:0] {
      PGM_INIT = 3'h0,
      PGM_GAIN = 3'h1,
      PGM_DTMF = 3'h2,
      PGM_RING = 3'h3,
      PGM_HANDSFREE = 3'h4
   } program_e;
   // Sequencer states, Gray along held, wait, run
   typedef enum logic [1:0] {
      ST_HELD = 2'h0,
      ST_WAIT = 2'h1,
      ST_RUN = 2'h3
   } dsp_state_e;
   // Reset and init-program defaults
   localparam logic [7:0] RESET_VALUE = 8'h00;
   localparam logic [5:0] INIT_RX_GAIN = 6'h00;
   localparam logic [7:0] INIT_TX_SPEECH = 8'h30;
   localparam logic [7:0] INIT_TX_TONE = 8'h2e;
   // Gain coding: 1.5 dB per code, four codes per 6 dB octave
   localparam logic [5:0] GAIN_UNITY = 6'h30;
   localparam logic [4:0] GAIN_SHIFT_BASE = 5'h1a;
   localparam logic [15:0] GAIN_MANT0 = 16'h4000;
   localparam logic [15:0] GAIN_MANT1 = 16'h4c17;
   localparam logic [15:0] GAIN_MANT2 = 16'h5a67;
   localparam logic [15:0] GAIN_MANT3 = 16'h6b71;
   // Tone amplitudes, high group 2 dB above low group
   localparam logic [12:0] LOW_TONE_AMP = 13'h0c33;
   localparam logic [12:0] HIGH_TONE_AMP = 13'h0f5c;
   localparam logic [15:0] RING_AMP = 16'h1000;
   // Phase of quarter period for cosine
   localparam logic [9:0] QUARTER_PHASE = 10'h100;
   // Samples per warble unit: 8000 / 500
   localparam logic [3:0] WARBLE_SHIFT = 4'h4;
   // Autonull averaging shift
   localparam int NULL_SHIFT = 6;
endpackage : voice_dsp_pkg

// *** test/frame_source.sv ***
// Frame pulse source standing in for the PCM bus timing
`timescale 1ns/1ns
module frame_source #(
   parameter int FRAME_CYC = 40
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Frame pulse
   output logic framePulse
);
   logic [7:0] frameCnt_q;
   ////////////////////////////////////////
   // Three-cycle pulse at each frame start
   always_ff @(posedge clk) begin
      if (!rstn) begin
         frameCnt_q <= 8'h00;
         framePulse <= 1'b0;
      end else begin
         if (frameCnt_q == 8'(FRAME_CYC - 1)) begin
            frameCnt_q <= 8'h00;
         end else begin
            frameCnt_q <= frameCnt_q + 8'h01;
         end
         framePulse <= (frameCnt_q < 8'h03);
      end
   end
endmodule : frame_source

// *** test/voice_gain_tone_generator_bench.sv ***
// Self-checking bench for the voice gain and tone generator
`timescale 1ns/1ns
module voice_gain_tone_generator_bench;
   import voice_dsp_pkg::*;
   typedef struct {
      int k;
      logic signed [15:0] r;
      logic signed [15:0] t;
   } exp_s;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic regWrEn = 1'b0;
   logic [7:0] regAddr;
   logic [7:0] regWrData;
   logic [7:0] regRdData;
   logic framePulse;
   logic signed [15:0] rxPcm;
   logic signed [15:0] txPcm;
   logic signed [15:0] rxOut;
   logic signed [15:0] txOut;
   logic signed [15:0] nr;
   logic signed [15:0] nt;
   logic sampleValid;
   logic newCallTone;
   logic fpPrev = 1'b0;
   logic nctPrev = 1'b0;
   logic dcTx = 1'b0;
   logic [31:0] a;
   logic [31:0] b;
   logic [31:0] rv;
   int n_fail = 0;
   int n_tests = 0;
   int kind = 1;
   int rxSh = 0;
   int txSh = 0;
   int nctTog = 0;
   exp_s q[$];
   exp_s m;
   localparam logic [7:0] ALL [8] = '{OFF_RX_GAIN, OFF_DSP_CTRL,
      OFF_TX_SPEECH, OFF_TX_TONE, OFF_COEF_LOW, OFF_COEF_HIGH, OFF_WARBLE,
      8'h22};

   always #5 clk = ~clk;

   frame_source #(.FRAME_CYC(40)) i_src (
      .clk(clk),
      .rstn(rstn),
      .framePulse(framePulse)
   );

   voice_gain_tone_generator i_dut (
      .clk(clk),
      .rstn(rstn),
      .regWrEn(regWrEn),
      .regAddr(regAddr),
      .regWrData(regWrData),
      .regRdData(regRdData),
      .framePulse(framePulse),
      .rxPcm(rxPcm),
      .txPcm(txPcm),
      .rxOut(rxOut),
      .txOut(txOut),
      .sampleValid(sampleValid),
      .newCallTone(newCallTone)
   );

   ////////////////////////////////////////
   function automatic logic signed [15:0] sh(logic signed [15:0] x, int s);
      return (s >= 0) ? (x <<< s) : (x >>> -s);
   endfunction : sh

   function automatic bit oob(logic signed [15:0] v, int lim);
      return $isunknown(v) || v > lim || v < -lim;
   endfunction : oob

   task automatic bad(input string s);
      n_fail++;
      $display("BAD %0t %s", $time, s);
   endtask : bad

   task automatic final_report;
      $display("Checks %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : final_report

   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      regWrEn <= 1'b1;
      regAddr <= ad;
      regWrData <= d;
      @(posedge clk);
      regWrEn <= 1'b0;
      @(posedge clk);
   endtask : wr

   task automatic rd(input logic [7:0] ad, input logic [7:0] x);
      regAddr <= ad;
      repeat (2) @(posedge clk);
      n_tests++;
      if (regRdData !== x) bad($sformatf("read %h got %h", ad, regRdData));
   endtask : rd

   task automatic frames(input int n);
      int w;
      for (int i = 0; i < n; i++) begin
         w = 0;
         do begin
            @(posedge clk);
            w++;
         end while (!(framePulse === 1'b1 && fpPrev === 1'b0) && w < 100);
         if (w >= 100) begin
            bad("no frame");
            final_report();
         end
      end
      repeat (8) @(posedge clk);
   endtask : frames

   task automatic mode(input int k, input int r, input int t);
      kind <= k;
      rxSh <= r;
      txSh <= t;
   endtask : mode

   task automatic go(input logic [7:0] c, input int k, input int r,
      input int t, input int n);
      mode(0, 0, 0);
      wr(OFF_DSP_CTRL, c);
      frames(1);
      mode(k, r, t);
      frames(n);
   endtask : go

   ////////////////////////////////////////
   // Sample source and expectation notes
   always @(posedge clk) begin
      fpPrev <= framePulse;
      nctPrev <= newCallTone;
      if (rstn && newCallTone !== nctPrev) nctTog++;
      if (framePulse === 1'b1 && fpPrev === 1'b0) begin
         a = $urandom;
         b = $urandom;
         nr = {{3{a[9]}}, a[9:0], 3'h0};
         nt = dcTx ? 16'sh0040 : {{3{b[9]}}, b[9:0], 3'h0};
         rxPcm <= nr;
         txPcm <= nt;
         q.push_back('{kind, sh(nr, rxSh), sh(nt, txSh)});
      end
   end

   // Output watcher
   always @(posedge clk) begin
      if (sampleValid === 1'b1) begin
         if (q.size() == 0) bad("sample with no note");
         else begin
            m = q.pop_front();
            if (m.k != 0) n_tests++;
            if (m.k == 1 && (rxOut !== m.r || txOut !== m.t)) bad("gain");
            if (m.k == 2 && ((rxOut !== 16'sh1000 && rxOut !== 16'shf000)
                || txOut !== m.t)) bad("ringer");
            if (m.k == 3 && oob(txOut, 1)) bad("offset left");
            if (m.k == 4 && (rxOut !== m.r || oob(txOut, HIGH_TONE_AMP)))
               bad("tone to transmit");
         end
      end
   end

   initial begin
      #1_000_000;
      bad("run too long");
      final_report();
   end

   initial begin
      void'($urandom(32'h62f4_7610));
      regAddr = 8'h00;
      regWrData = 8'h00;
      rxPcm = 16'sh0000;
      txPcm = 16'sh0000;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      foreach (ALL[i]) rd(ALL[i], 8'h00);
      frames(2);
      wr(OFF_TX_SPEECH, 8'h11);
      rd(OFF_TX_SPEECH, 8'h00);
      wr(OFF_COEF_HIGH, 8'h11);
      rd(OFF_COEF_HIGH, 8'h00);
      wr(OFF_DSP_CTRL, 8'h80);
      for (int i = 2; i < 7; i++) begin
         rv = $urandom;
         wr(ALL[i], {2'h0, rv[5:0]});
         rd(ALL[i], {2'h0, rv[5:0]});
      end
      wr(8'h22, 8'h5a);
      rd(8'h22, 8'h00);
      mode(0, 0, 0);
      wr(OFF_DSP_CTRL, 8'h00);
      frames(3);
      rd(OFF_DSP_CTRL, 8'h40);
      wr(OFF_DSP_CTRL, 8'h80);
      rd(OFF_RX_GAIN, 8'h00);
      rd(OFF_TX_SPEECH, 8'h30);
      rd(OFF_TX_TONE, 8'h2e);
      wr(OFF_TX_SPEECH, 8'h2c);
      wr(OFF_RX_GAIN, 8'h34);
      go(8'h01, 1, 1, -1, 6);
      txSh <= -1;
      frames(1);
      mode(1, 1, -1);
      frames(5);
      wr(OFF_RX_GAIN, 8'h28);
      mode(1, -2, -1);
      frames(5);
      mode(0, 0, 0);
      dcTx <= 1'b1;
      wr(OFF_RX_GAIN, 8'h70);
      frames(700);
      mode(3, 0, 0);
      frames(3);
      dcTx <= 1'b0;
      mode(0, 0, 0);
      wr(OFF_DSP_CTRL, 8'h80);
      wr(OFF_TX_SPEECH, 8'h30);
      wr(OFF_TX_TONE, 8'h30);
      wr(OFF_COEF_LOW, 8'h04);
      wr(OFF_COEF_HIGH, 8'h06);
      wr(OFF_WARBLE, 8'h01);
      wr(OFF_RX_GAIN, 8'h30);
      go(8'h03, 2, 0, 0, 40);
      n_tests++;
      if (nctTog != 0) bad("tone pin moved");
      go(8'h0b, 1, 0, 0, 20);
      n_tests++;
      if (nctTog < 2) bad("tone pin idle");
      go(8'h80, 0, 0, 0, 1);
      wr(OFF_COEF_LOW, 8'h00);
      wr(OFF_COEF_HIGH, 8'h9b);
      go(8'h12, 4, 0, 0, 20);
      for (int c = 4; c < 8; c++) go(8'(c), 1, 0, 0, 3);
      final_report();
   end
endmodule : voice_gain_tone_generator_bench
